/* core/brfa_cfg.svh */
// Constants for the banked register file address decoder.
// Assumes inclusion by the package and the decoder only.
//
// Behaviour
// - Bank 0: ports, general storage, control/status
// - Expanded register groups live in banks D, F
// - Full 8-bit direct or indirect addresses accepted
// - Short addresses see 16 groups of 16 in bank 0
// - Short address offsets from working group pointer
// - Counter/timer registers sit in expanded bank D
// - Pointer zero selects bank 0, group 0
`ifndef BRFA_CFG_SVH
`define BRFA_CFG_SVH
`define BRFA_PORT_LAST 8'h03
`define BRFA_GP_LAST 8'hEF
`define BRFA_BANK_MAIN 4'h0
`define BRFA_BANK_TIMER 4'hD
`define BRFA_BANK_SYS 4'hF
`define BRFA_PTR_RST 8'h00
`define BRFA_GRP_MSB 7
`define BRFA_GRP_LSB 4
`define BRFA_BANK_MSB 3
`define BRFA_BANK_LSB 0
`define BRFA_EXP_FIRST 8'h00
`define BRFA_EXP_LAST 8'h0F
`endif

/* core/brfa_pkg.sv */
// Types for the banked register file address decoder.
// Assumes the constants header is on the include path.
`include "brfa_cfg.svh"
package brfa_pkg;
  // Kind of location that one access resolves to
  typedef enum logic [2:0] {
    BRFA_SPACE_PORT,
    BRFA_SPACE_GP,
    BRFA_SPACE_CTRL,
    BRFA_SPACE_EXP_TIMER,
    BRFA_SPACE_EXP_SYS,
    BRFA_SPACE_NONE
  } brfa_space_e;

  // One access request from the instruction logic
  typedef struct packed {
    logic valid;
    logic short_mode;
    logic [7:0] addr;
  } brfa_req_s;

  // One decoded access
  typedef struct packed {
    logic valid;
    brfa_space_e space;
    logic [3:0] bank;
    logic [7:0] addr;
  } brfa_dec_s;
endpackage : brfa_pkg

/* core/brfa_decoder.sv */
// Register file address decoder with working group pointer.
// Assumes the core drives requests on clk_sys_i; one cycle latency.
// Assumes the package and the constants header are read before it.
`timescale 1ns/1ps
`include "brfa_cfg.svh"
module brfa_decoder (
  input wire logic clk_sys_i, // Core clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire brfa_pkg::brfa_req_s req_i, // Access request
  input wire logic ptr_we_i, // Load working group pointer
  input wire logic [7:0] ptr_wdata_i, // New pointer value
  output brfa_pkg::brfa_dec_s dec_o, // Decoded access
  output logic [7:0] working_group_pointer_o // Current pointer
);
  // Pointer and output registers
  logic [7:0] ptr_reg;
  brfa_pkg::brfa_dec_s dec_reg;
  brfa_pkg::brfa_dec_s dec_next;
  // Fields of the pointer
  logic [3:0] grp;
  logic [3:0] bank;
  // Which bank the low nibble of the pointer names
  logic sel_main;
  logic sel_timer;
  logic sel_sys;
  // Resolved location of the current request
  logic [3:0] res_bank;
  logic [7:0] res_addr;
  brfa_pkg::brfa_space_e main_space;

  // Pointer register, zero at reset. A load in the same cycle as a short
  // request takes effect only after that request has been resolved.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ptr_reg <= `BRFA_PTR_RST;
    end else if (ptr_we_i) begin
      ptr_reg <= ptr_wdata_i;
    end
  end

  // Upper nibble picks the working group, lower nibble the bank
  assign grp = ptr_reg[`BRFA_GRP_MSB:`BRFA_GRP_LSB];
  assign bank = ptr_reg[`BRFA_BANK_MSB:`BRFA_BANK_LSB];

  // Bank decode of the low nibble; codes other than these name no bank
  assign sel_main = (bank == `BRFA_BANK_MAIN);
  assign sel_timer = (bank == `BRFA_BANK_TIMER);
  assign sel_sys = (bank == `BRFA_BANK_SYS);

  // Address resolution. Full addresses always land in bank 0; a short
  // address takes the group nibble in bank 0, or stands alone as an
  // offset inside an expanded bank, where the group is ignored.
  always_comb begin
    res_bank = `BRFA_BANK_MAIN;
    res_addr = req_i.addr;
    if (req_i.short_mode) begin
      if (sel_timer || sel_sys) begin
        res_bank = bank;
        res_addr = {4'h0, req_i.addr[3:0]};
      end else begin
        res_addr = {grp, req_i.addr[3:0]};
      end
    end
  end

  // Region of the resolved address within bank 0
  always_comb begin
    if (res_addr <= `BRFA_PORT_LAST) begin
      main_space = brfa_pkg::BRFA_SPACE_PORT;
    end else if (res_addr <= `BRFA_GP_LAST) begin
      main_space = brfa_pkg::BRFA_SPACE_GP;
    end else begin
      main_space = brfa_pkg::BRFA_SPACE_CTRL;
    end
  end

  // Decoded access. A short access whose bank nibble names no bank is
  // reported as no space, so that it cannot alias onto bank 0 storage.
  always_comb begin
    dec_next = '0;
    dec_next.valid = req_i.valid;
    dec_next.bank = res_bank;
    dec_next.addr = res_addr;
    if (!req_i.short_mode || sel_main) begin
      dec_next.space = main_space;
    end else if (sel_timer) begin
      dec_next.space = brfa_pkg::BRFA_SPACE_EXP_TIMER;
    end else if (sel_sys) begin
      dec_next.space = brfa_pkg::BRFA_SPACE_EXP_SYS;
    end else begin
      dec_next.space = brfa_pkg::BRFA_SPACE_NONE;
    end
  end

  // Registered decode output, cleared by reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  // Outputs straight from their registers
  assign dec_o = dec_reg;
  assign working_group_pointer_o = ptr_reg;

  // Checks. Antecedents read the pointer register rather than the decoded
  // nibbles, so that a broken bank decode cannot hide behind itself.
  // Expected regions come from the boundary constants.
  // Pointer is zero on the first edge after reset
  ptr_reset_a: assert property (@(posedge clk_sys_i)
    $fell(sys_rst_i) |-> ptr_reg == `BRFA_PTR_RST)
    else $error("pointer not zero after reset");

  // Reset clears the decode output and the pointer
  reset_clear_a: assert property (@(posedge clk_sys_i)
    sys_rst_i |=> dec_o == '0 && working_group_pointer_o == `BRFA_PTR_RST)
    else $error("reset did not clear outputs");

  // Short address in bank 0 is offset from the working group base
  short_group_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode && ptr_reg[3:0] == `BRFA_BANK_MAIN |=>
    dec_o.addr == {$past(ptr_reg[7:4]), $past(req_i.addr[3:0])})
    else $error("short address not offset by group");

  // Group of a short bank 0 access is the pointer's upper nibble
  group_span_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode && ptr_reg[3:0] == `BRFA_BANK_MAIN |=>
    dec_o.addr[7:4] == $past(ptr_reg[7:4]) && dec_o.bank == `BRFA_BANK_MAIN)
    else $error("group not from high nibble");

  // Pointer zero keeps short accesses in bank 0, group 0
  bank0_stay_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode && ptr_reg == `BRFA_PTR_RST |=> dec_o.bank == `BRFA_BANK_MAIN &&
    dec_o.addr[7:4] == 4'h0 && dec_o.space != brfa_pkg::BRFA_SPACE_NONE)
    else $error("pointer zero left bank 0 group 0");

  // Full addresses pass unchanged into bank 0
  direct_addr_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && !req_i.short_mode |=>
    dec_o.addr == $past(req_i.addr) && dec_o.bank == `BRFA_BANK_MAIN)
    else $error("direct address altered");

  // Output valid follows the request one cycle later
  valid_copy_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1 |=> dec_o.valid == $past(req_i.valid))
    else $error("decode valid does not follow request");

  // Port registers are exactly the lowest bank 0 locations
  port_space_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && (!req_i.short_mode || ptr_reg[3:0] == `BRFA_BANK_MAIN) |=>
    (dec_o.space == brfa_pkg::BRFA_SPACE_PORT) == (dec_o.addr <= `BRFA_PORT_LAST))
    else $error("port space wrong");

  // General storage is exactly the middle bank 0 locations
  gp_space_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && (!req_i.short_mode || ptr_reg[3:0] == `BRFA_BANK_MAIN) |=>
    (dec_o.space == brfa_pkg::BRFA_SPACE_GP) == (dec_o.addr > `BRFA_PORT_LAST && dec_o.addr <= `BRFA_GP_LAST))
    else $error("general storage space wrong");

  // Control and status registers are exactly the top bank 0 locations
  ctrl_space_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && (!req_i.short_mode || ptr_reg[3:0] == `BRFA_BANK_MAIN) |=>
    (dec_o.space == brfa_pkg::BRFA_SPACE_CTRL) == (dec_o.addr > `BRFA_GP_LAST))
    else $error("control space wrong");

  // Bank D short accesses reach the counter/timer registers
  timer_bank_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode && ptr_reg[3:0] == `BRFA_BANK_TIMER |=>
    dec_o.space == brfa_pkg::BRFA_SPACE_EXP_TIMER && dec_o.bank == `BRFA_BANK_TIMER)
    else $error("bank D not timer space");

  // Bank F short accesses reach the second expanded group
  sys_bank_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode && ptr_reg[3:0] == `BRFA_BANK_SYS |=>
    dec_o.space == brfa_pkg::BRFA_SPACE_EXP_SYS && dec_o.bank == `BRFA_BANK_SYS)
    else $error("bank F not expanded space");

  // Expanded banks see only the short offset, never the group
  exp_offset_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode &&
    (ptr_reg[3:0] == `BRFA_BANK_TIMER || ptr_reg[3:0] == `BRFA_BANK_SYS) |=> dec_o.addr <= `BRFA_EXP_LAST &&
    dec_o.addr[3:0] == $past(req_i.addr[3:0]) && dec_o.bank == $past(ptr_reg[3:0]))
    else $error("expanded offset wrong");

  // A bank nibble that names no bank gives no space
  none_space_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    req_i.valid && req_i.short_mode &&
    !(ptr_reg[3:0] inside {`BRFA_BANK_MAIN, `BRFA_BANK_TIMER, `BRFA_BANK_SYS}) |=>
    dec_o.space == brfa_pkg::BRFA_SPACE_NONE && dec_o.bank == `BRFA_BANK_MAIN)
    else $error("unnamed bank not reported as no space");

  // A pointer load shows on the next cycle
  ptr_load_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ptr_we_i |=> working_group_pointer_o == $past(ptr_wdata_i))
    else $error("pointer load lost");

  // Without a load the pointer holds its value
  ptr_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !ptr_we_i |=> $stable(working_group_pointer_o))
    else $error("pointer changed without a load");

  // Main scenarios reached
  // Counter/timer bank access
  timer_cov: cover property (@(posedge clk_sys_i)
    dec_o.valid && dec_o.space == brfa_pkg::BRFA_SPACE_EXP_TIMER);

  // Second expanded bank access
  sys_cov: cover property (@(posedge clk_sys_i)
    dec_o.valid && dec_o.space == brfa_pkg::BRFA_SPACE_EXP_SYS);

  // General storage access
  gp_cov: cover property (@(posedge clk_sys_i)
    dec_o.valid && dec_o.space == brfa_pkg::BRFA_SPACE_GP);

  // Control and status access
  ctrl_cov: cover property (@(posedge clk_sys_i)
    dec_o.valid && dec_o.space == brfa_pkg::BRFA_SPACE_CTRL);

  // Short access through a nibble that names no bank
  none_cov: cover property (@(posedge clk_sys_i)
    dec_o.valid && dec_o.space == brfa_pkg::BRFA_SPACE_NONE);
endmodule : brfa_decoder

/* bench/brfa_core_model.sv */
// Core-side model that issues decode requests and pointer loads.
// Assumes the bench clock; it drives just after each rising edge.
`timescale 1ns/1ps
module brfa_core_model (
  input wire logic clk_sys_i, // Core clock
  output brfa_pkg::brfa_req_s req_o, // Access request
  output logic ptr_we_o, // Pointer load strobe
  output logic [7:0] ptr_wdata_o // Pointer value
);
  initial begin
    req_o = '0;
    ptr_we_o = 1'b0;
    ptr_wdata_o = 8'h00;
  end
  // One cycle of request and load, then idle with the address and data inverted
  task automatic issue(input logic v, input logic s, input logic [7:0] a, input logic w, input logic [7:0] p);
    @(posedge clk_sys_i);
    req_o <= {v, s, a};
    ptr_we_o <= w;
    ptr_wdata_o <= p;
    @(posedge clk_sys_i);
    req_o <= {1'b0, s, ~a};
    ptr_we_o <= 1'b0;
    ptr_wdata_o <= ~p;
  endtask : issue
endmodule : brfa_core_model

/* bench/banked_register_file_addressing_bench.sv */
// Bench for the register file address decoder.
// Assumes the core model drives the request and pointer load inputs; the bench drives clock and reset.
`timescale 1ns/1ps
module banked_register_file_addressing_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  brfa_pkg::brfa_req_s req;
  logic we;
  logic [7:0] wd;
  brfa_pkg::brfa_dec_s dec;
  logic [7:0] ptr;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  brfa_core_model core (.clk_sys_i(clk_sys_i), .req_o(req), .ptr_we_o(we), .ptr_wdata_o(wd));
  brfa_decoder DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req), .ptr_we_i(we),
    .ptr_wdata_i(wd), .dec_o(dec), .working_group_pointer_o(ptr));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // Compare the decode a settled step after the answer edge
  task automatic cmp_dec(input brfa_pkg::brfa_space_e sp, input logic [3:0] bk, input logic [7:0] ad);
    brfa_pkg::brfa_dec_s e;
    e = {1'b1, sp, bk, ad};
    #1;
    n_checks++;
    if (dec !== e) begin
      fail_count++;
      $display("unexpected dec_o: expected %h seen %h", e, dec);
    end
  endtask : cmp_dec
  task automatic cmp_ptr(input logic [7:0] e);
    #1;
    n_checks++;
    if (ptr !== e) begin
      fail_count++;
      $display("unexpected pointer: expected %h seen %h", e, ptr);
    end
  endtask : cmp_ptr
  // Pointer zero maps short offsets onto bank 0, group 0
  task automatic t_reset();
    cmp_ptr(8'h00);
    core.issue(1'b1, 1'b1, 8'h03, 1'b1, 8'h7D);
    cmp_dec(brfa_pkg::BRFA_SPACE_PORT, 4'h0, 8'h03);
  endtask : t_reset
  // Short offsets through group and bank nibbles
  task automatic t_banks();
    cmp_ptr(8'h7D);
    core.issue(1'b1, 1'b1, 8'h01, 1'b1, 8'h3F);
    cmp_dec(brfa_pkg::BRFA_SPACE_EXP_TIMER, 4'hD, 8'h01);
    core.issue(1'b1, 1'b1, 8'h0C, 1'b1, 8'h50);
    cmp_dec(brfa_pkg::BRFA_SPACE_EXP_SYS, 4'hF, 8'h0C);
    core.issue(1'b1, 1'b1, 8'h09, 1'b1, 8'hE7);
    cmp_dec(brfa_pkg::BRFA_SPACE_GP, 4'h0, 8'h59);
    core.issue(1'b1, 1'b1, 8'h02, 1'b0, 8'h00);
    cmp_dec(brfa_pkg::BRFA_SPACE_NONE, 4'h0, 8'hE2);
  endtask : t_banks
  // Full addresses reach bank 0 with the pointer left at E7, a bank nibble that names no bank
  task automatic t_direct();
    logic [7:0] a[6] = '{8'h00, 8'h03, 8'h04, 8'hEF, 8'hF0, 8'hFF};
    foreach (a[i]) begin
      core.issue(1'b1, 1'b0, a[i], 1'b0, 8'h00);
      cmp_dec(a[i] < 8'h04 ? brfa_pkg::BRFA_SPACE_PORT : a[i] < 8'hF0 ? brfa_pkg::BRFA_SPACE_GP :
        brfa_pkg::BRFA_SPACE_CTRL, 4'h0, a[i]);
    end
  endtask : t_direct
  // Mid-run reset returns the pointer to bank 0, group 0
  task automatic t_rerun();
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    cmp_ptr(8'h00);
    core.issue(1'b1, 1'b1, 8'h0E, 1'b0, 8'h00);
    cmp_dec(brfa_pkg::BRFA_SPACE_GP, 4'h0, 8'h0E);
  endtask : t_rerun
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_banks();
    t_direct();
    t_rerun();
    give_verdict();
  end
endmodule : banked_register_file_addressing_bench
